//--- design/dlis_pkg.sv
// Package for the descriptor loader: constants and carrier types
package dlis_pkg;
    localparam logic [7:0]  ROM_DEV_ADDR    = 8'ha0;
    localparam logic [7:0]  ROM_START_LOC   = 8'h00;
    localparam int          DESC_BYTES      = 57;
    localparam int          XTI_DIV         = 384;
    localparam int          QTR_DIV         = XTI_DIV / 4;
    localparam int          WORD_BITS       = 16;
    localparam int          BIT_TYPE        = 11;
    localparam int          BIT_RESTART     = 9;
    localparam logic [15:0] RSVD_MASK       = 16'hf500;
    localparam logic [7:0]  HID_RESET_VAL   = 8'h00;
    localparam int          STR_PROD_FIRST  = 4;
    localparam int          STR_VEND_LAST   = 51;

    typedef enum logic [3:0] {
        DLIS_IDLE  = 4'h0,
        DLIS_START = 4'h1,
        DLIS_ADDR  = 4'h2,
        DLIS_AACK  = 4'h3,
        DLIS_DATA  = 4'h4,
        DLIS_MACK  = 4'h5,
        DLIS_STOP  = 4'h6,
        DLIS_DONE  = 4'h7
    } dlis_state_t;

    typedef struct packed {
        logic [5:0] index;
        logic [7:0] data;
        logic       is_string;
    } dlis_byte_t;
endpackage : dlis_pkg

//--- design/dlis_loader.sv
// Descriptor loader: two-wire ROM reader and three-wire command port
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Fetch ROM image once after power-on reset
// - NACK USB requests until fetch completes
// - Address ROM with device byte 0xA0
// - Read 57 bytes starting at location zero
// - Bytes arrive LSB first; reassemble accordingly
// - ROM bit rate is crystal over 384
// - Image field order fixed by byte index
// - String bytes flagged for unicode expansion
// - START, address+R, ack, data+acks, final NACK, STOP
// - Sixteen-bit word with fixed zero bits
// - Type clear: payload gives HID states
// - Type set: payload is next descriptor byte
// - Restart bit in a type-clear word clears the descriptor byte counter
// - Restart word still updates HID status
module dlis_loader #(
    parameter int QTR_CYCLES = dlis_pkg::QTR_DIV
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    // Two-wire ROM pins, enable low drives low
    input  wire logic             ROM_SERIAL_DATA_I,
    output logic                  ROM_SERIAL_DATA_OE_N,
    output logic                  ROM_BIT_TIMING_LINE_OE_N,
    // Three-wire command port
    input  wire logic             FRAME_SELECT_LINE,
    input  wire logic             SHIFT_TIMING_INPUT,
    input  wire logic             SERIAL_INPUT_LINE,
    // Descriptor byte stream out
    output dlis_pkg::dlis_byte_t  DESC_BYTE,
    output logic                  DESC_VALID,
    input  wire logic             DESC_READY,
    // Status
    output logic [7:0]            HID_STATE,
    output logic                  USB_NACK_ALL,
    output logic                  CMD_ERROR
);
    import dlis_pkg::*;

    typedef struct packed {
        logic [1:0]  fs_sync;
        logic [1:0]  sc_sync;
        logic [1:0]  sd_sync;
        logic [1:0]  rd_sync;
        logic        fs_prev;
        logic        sc_prev;
        dlis_state_t st;
        logic [7:0]  div;
        logic [1:0]  phase;
        logic [3:0]  bitn;
        logic [7:0]  shreg;
        logic [5:0]  rom_cnt;
        logic        sda_oe_n;
        logic        scl_oe_n;
        logic        nack_all;
        logic [4:0]  spi_cnt;
        logic [15:0] spi_sh;
        logic [5:0]  desc_cnt;
        logic [7:0]  hid;
        logic        err;
        logic        in_valid;
        dlis_byte_t  in_byte;
        dlis_byte_t  buf0;
        dlis_byte_t  buf1;
        logic [1:0]  fill;
        logic        out_vld;
    } dlis_reg_t;
    localparam dlis_reg_t Q_RESET = '{fs_sync: 2'b11, rd_sync: 2'b11, fs_prev: 1'b1, st: DLIS_IDLE,
                                      sda_oe_n: 1'b1, scl_oe_n: 1'b1, nack_all: 1'b1,
                                      hid: HID_RESET_VAL, default: '0};

    dlis_reg_t q, d;
    logic [1:0] rst_sync_q;
    logic      rst_n;
    logic      qtr_tick;
    logic      fs_rise;
    logic      sc_rise;
    logic      in_ready;
    logic      out_take;
    logic      push;
    logic      rom_stall;
    logic [7:0] payload;

    assign rst_n = rst_sync_q[1];

    // Reset release synchroniser
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    always_comb begin
        d = q;
        d.fs_sync = {q.fs_sync[0], FRAME_SELECT_LINE};
        d.sc_sync = {q.sc_sync[0], SHIFT_TIMING_INPUT};
        d.sd_sync = {q.sd_sync[0], SERIAL_INPUT_LINE};
        d.rd_sync = {q.rd_sync[0], ROM_SERIAL_DATA_I};
        d.fs_prev = q.fs_sync[1];
        d.sc_prev = q.sc_sync[1];
        fs_rise = q.fs_sync[1] & ~q.fs_prev;
        sc_rise = q.sc_sync[1] & ~q.sc_prev;
        // Payload bit 0 travels in word bit 7
        payload = {q.spi_sh[0], q.spi_sh[1], q.spi_sh[2], q.spi_sh[3],
                   q.spi_sh[4], q.spi_sh[5], q.spi_sh[6], q.spi_sh[7]};

        // Quarter-bit tick; four ticks make one ROM bit
        qtr_tick = (q.div == 8'(QTR_CYCLES - 1));
        d.div = qtr_tick ? 8'h00 : q.div + 8'h01;
        in_ready = (q.fill != 2'd2);
        out_take = q.out_vld && DESC_READY;
        // Full buffer parks the reader with the clock high in the ack bit, so no extra pulse
        rom_stall = (q.st == DLIS_MACK) && (q.phase == 2'd3) && !in_ready;
        if (qtr_tick && !rom_stall) begin
            d.phase = q.phase + 2'd1;
        end
        push = 1'b0;
        d.in_valid = 1'b0;

        // ROM reader; stalls between bytes while the buffer is full
        if (qtr_tick && !rom_stall) begin
            unique case (q.st)
                DLIS_IDLE: begin
                    d.sda_oe_n = 1'b1;
                    d.scl_oe_n = 1'b1;
                    if (q.phase == 2'd3) begin
                        d.st = DLIS_START;
                    end
                end
                DLIS_START: begin
                    if (q.phase == 2'd1) begin
                        d.sda_oe_n = 1'b0;
                    end
                    if (q.phase == 2'd3) begin
                        d.scl_oe_n = 1'b0;
                        d.st = DLIS_ADDR;
                        d.bitn = 4'd0;
                        d.shreg = ROM_DEV_ADDR | 8'h01;
                    end
                end
                DLIS_ADDR, DLIS_DATA, DLIS_AACK, DLIS_MACK: begin
                    unique case (q.phase)
                        2'd0: begin
                            if (q.st == DLIS_ADDR) begin
                                d.sda_oe_n = q.shreg[7];
                            end else if (q.st == DLIS_MACK) begin
                                d.sda_oe_n = (q.rom_cnt == 6'(DESC_BYTES));
                            end else begin
                                d.sda_oe_n = 1'b1;
                            end
                        end
                        2'd1: d.scl_oe_n = 1'b1;
                        2'd2: begin
                            if (q.st == DLIS_DATA) begin
                                d.shreg = {q.rd_sync[1], q.shreg[7:1]};
                            end
                        end
                        2'd3: begin
                            d.scl_oe_n = 1'b0;
                            unique case (q.st)
                                DLIS_ADDR: begin
                                    d.shreg = {q.shreg[6:0], 1'b0};
                                    d.bitn = q.bitn + 4'd1;
                                    if (q.bitn == 4'd7) begin
                                        d.st = DLIS_AACK;
                                    end
                                end
                                DLIS_AACK: begin
                                    d.st = DLIS_DATA;
                                    d.bitn = 4'd0;
                                end
                                DLIS_DATA: begin
                                    d.bitn = q.bitn + 4'd1;
                                    if (q.bitn == 4'd7) begin
                                        d.st = DLIS_MACK;
                                        d.rom_cnt = q.rom_cnt + 6'd1;
                                        d.in_valid = 1'b1;
                                        d.in_byte.index = q.rom_cnt;
                                        d.in_byte.data = q.shreg;
                                        d.in_byte.is_string = (q.rom_cnt >= 6'(STR_PROD_FIRST)) &&
                                            (q.rom_cnt <= 6'(STR_VEND_LAST));
                                    end
                                end
                                default: begin
                                    d.bitn = 4'd0;
                                    d.st = (q.rom_cnt == 6'(DESC_BYTES)) ? DLIS_STOP : DLIS_DATA;
                                end
                            endcase
                        end
                        default: ;
                    endcase
                end
                DLIS_STOP: begin
                    unique case (q.phase)
                        2'd0: d.sda_oe_n = 1'b0;
                        2'd1: d.scl_oe_n = 1'b1;
                        2'd3: begin
                            d.sda_oe_n = 1'b1;
                            d.st = DLIS_DONE;
                        end
                        default: ;
                    endcase
                end
                DLIS_DONE: d.nack_all = 1'b0;
                default: d.st = DLIS_IDLE;
            endcase
        end

        // Command port shift register
        if (q.fs_sync[1]) begin
            d.spi_cnt = 5'd0;
        end else if (sc_rise && q.spi_cnt != 5'(WORD_BITS)) begin
            d.spi_sh = {q.spi_sh[14:0], q.sd_sync[1]};
            d.spi_cnt = q.spi_cnt + 5'd1;
        end
        if (fs_rise && q.spi_cnt == 5'(WORD_BITS)) begin
            d.err = q.err | ((q.spi_sh & RSVD_MASK) != 16'h0000) |
                    (q.spi_sh[BIT_TYPE] & q.spi_sh[BIT_RESTART]);
            if (!q.spi_sh[BIT_TYPE]) begin
                d.hid = payload;
                if (q.spi_sh[BIT_RESTART]) begin
                    d.desc_cnt = 6'd0;
                end
            end else if (!q.spi_sh[BIT_RESTART] && q.desc_cnt != 6'(DESC_BYTES)) begin
                d.in_valid = 1'b1;
                d.in_byte.index = q.desc_cnt;
                d.in_byte.data = payload;
                d.in_byte.is_string = (q.desc_cnt >= 6'(STR_PROD_FIRST)) &&
                    (q.desc_cnt <= 6'(STR_VEND_LAST));
                d.desc_cnt = q.desc_cnt + 6'd1;
            end
        end

        // Two-entry buffer
        push = q.in_valid && in_ready;
        unique case ({push, out_take})
            2'b10: begin
                if (q.fill == 2'd0) d.buf0 = q.in_byte;
                else d.buf1 = q.in_byte;
                d.fill = q.fill + 2'd1;
            end
            2'b01: begin
                d.buf0 = q.buf1;
                d.fill = q.fill - 2'd1;
            end
            2'b11: begin
                if (q.fill == 2'd1) d.buf0 = q.in_byte;
                else begin
                    d.buf0 = q.buf1;
                    d.buf1 = q.in_byte;
                end
            end
            default: ;
        endcase
        d.out_vld = (d.fill != 2'd0);
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= Q_RESET;
        end else begin
            q <= d;
        end
    end

    assign ROM_SERIAL_DATA_OE_N     = q.sda_oe_n;
    assign ROM_BIT_TIMING_LINE_OE_N = q.scl_oe_n;
    assign DESC_BYTE                = q.buf0;
    assign DESC_VALID               = q.out_vld;
    assign HID_STATE                = q.hid;
    assign USB_NACK_ALL             = q.nack_all;
    assign CMD_ERROR                = q.err;

    // Checks
    property p_nack_until_done;
        @(posedge CLK) disable iff (!rst_n) (q.st != DLIS_DONE) |-> USB_NACK_ALL;
    endproperty
    a_nack_until_done: assert property (p_nack_until_done) else $error("nack dropped early");

    property p_tick_period;
        @(posedge CLK) disable iff (!rst_n) qtr_tick |=> !qtr_tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("bit timing too fast");

    property p_rom_limit;
        @(posedge CLK) disable iff (!rst_n) q.rom_cnt <= 6'(DESC_BYTES);
    endproperty
    a_rom_limit: assert property (p_rom_limit) else $error("read past image");

    property p_restart;
        @(posedge CLK) disable iff (!rst_n)
            (fs_rise && q.spi_cnt == 5'(WORD_BITS) && !q.spi_sh[BIT_TYPE] && q.spi_sh[BIT_RESTART])
            |=> (q.desc_cnt == 6'd0) && (HID_STATE == $past(payload));
    endproperty
    a_restart: assert property (p_restart) else $error("restart word mishandled");

    property p_hid;
        @(posedge CLK) disable iff (!rst_n)
            (fs_rise && q.spi_cnt == 5'(WORD_BITS) && !q.spi_sh[BIT_TYPE]) |=> HID_STATE == $past(payload);
    endproperty
    a_hid: assert property (p_hid) else $error("hid not updated");

    property p_data_rev;
        @(posedge CLK) disable iff (!rst_n)
            (fs_rise && q.spi_cnt == 5'(WORD_BITS) && q.spi_sh[BIT_TYPE] && !q.spi_sh[BIT_RESTART]
             && q.desc_cnt != 6'(DESC_BYTES)) |=> q.in_valid && q.in_byte.data[0] == $past(q.spi_sh[7]);
    endproperty
    a_data_rev: assert property (p_data_rev) else $error("payload bit order wrong");

    property p_hold_full;
        @(posedge CLK) disable iff (!rst_n) (q.fill == 2'd2 && !DESC_READY) |=> $stable(DESC_BYTE);
    endproperty
    a_hold_full: assert property (p_hold_full) else $error("buffer head changed under stall");

    property p_stop_release;
        @(posedge CLK) disable iff (!rst_n) (q.st == DLIS_DONE) |-> ROM_SERIAL_DATA_OE_N && ROM_BIT_TIMING_LINE_OE_N;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("bus held after stop");

    c_done: cover property (@(posedge CLK) disable iff (!rst_n) $fell(USB_NACK_ALL));
    c_full: cover property (@(posedge CLK) disable iff (!rst_n) q.fill == 2'd2);
    c_cmd: cover property (@(posedge CLK) disable iff (!rst_n) fs_rise && q.spi_cnt == 5'(WORD_BITS));
endmodule : dlis_loader

`default_nettype wire

//--- tb/dlis_rom_model.sv
// Two-wire serial ROM model holding the descriptor image
`timescale 1ns/1ps
`default_nettype none
module dlis_rom_model #(
    parameter int IMG_BYTES = 57
) (
    // Clock and bus levels
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    // Pull-down request and status
    output var logic  sda_low,
    output var int    starts,
    output var int    sent,
    output var logic  addr_ok,
    output var logic  nack_last,
    output var logic  stopped
);
    logic       scl_p;
    logic       sda_p;
    logic       rd;
    logic       ackd;
    logic [7:0] sh;
    int         bitn;

    // Power fields hold a bus-powered pair; the rest is a pattern
    function automatic logic [7:0] img(input int i);
        if (i == 52) return 8'h80;
        if (i == 53) return 8'h7d;
        return 8'((i * 29) ^ 8'h5a);
    endfunction

    initial begin
        {scl_p, sda_p} = 2'b11;
        {sda_low, addr_ok, nack_last, stopped, rd, ackd} = 6'h00;
        {starts, sent, bitn} = {32'h0, 32'h0, 32'h0};
        sh = 8'h00;
    end

    always @(posedge clk) begin
        scl_p <= scl;
        sda_p <= sda;
        if (scl && scl_p && sda_p && !sda) begin
            starts <= starts + 1;
            {bitn, rd, ackd} <= {32'h0, 2'b00};
        end else if (scl && scl_p && !sda_p && sda) begin
            stopped <= 1'b1;
        end else if (scl && !scl_p) begin
            if (!rd && bitn < 8) begin
                sh <= {sh[6:0], sda};
            end
            if (rd && bitn == 8) begin
                // Low ack asks for more, high ends the read
                sent <= sent + 1;
                if (sda) begin
                    nack_last <= (sent + 1 == IMG_BYTES);
                end
            end
            bitn <= (bitn == 8) ? 0 : bitn + 1;
        end else if (!scl && scl_p) begin
            if (!rd && bitn == 8) begin
                addr_ok <= (sh == 8'ha1);
                sda_low <= 1'b1;
                ackd <= 1'b1;
            end else if (!ackd || bitn == 8 || sent >= IMG_BYTES) begin
                sda_low <= 1'b0;
            end else begin
                // Stored as is and sent from bitn 0 upward, so the wire carries bit 0 first
                rd <= 1'b1;
                sda_low <= (((img(sent) >> bitn) & 8'h01) == 8'h00);
            end
        end
    end
endmodule // dlis_rom_model
`default_nettype wire

//--- tb/dlis_loader_tb_top.sv
// Self-checking testbench for the descriptor loader
`timescale 1ns/1ps
`default_nettype none
module dlis_loader_tb_top;
    import dlis_pkg::*;
    // Shortened quarter-bit so a whole image read fits the run
    localparam int TB_QTR = 24;
    logic       clk;
    logic       reset_n;
    logic       frame_n;
    logic       shift;
    logic       ser;
    logic       ready;
    logic       sda_oe_n;
    logic       scl_oe_n;
    logic       sda_low;
    wire logic  sda_w;
    dlis_byte_t desc;
    logic       valid;
    logic [7:0] hid;
    logic       nack_all;
    logic       err;
    logic       addr_ok;
    logic       nack_last;
    logic       stopped;
    int         starts;
    int         sent;
    int         failures;
    int         check_count;
    int         cycles;
    time        t0;
    dlis_byte_t got_q[$];

    // Open-drain data line with pull-up
    assign sda_w = sda_oe_n & ~sda_low;

    dlis_loader #(.QTR_CYCLES(TB_QTR)) i_dlis_loader (
        .CLK                      (clk),
        .RESET_N                  (reset_n),
        .ROM_SERIAL_DATA_I        (sda_w),
        .ROM_SERIAL_DATA_OE_N     (sda_oe_n),
        .ROM_BIT_TIMING_LINE_OE_N (scl_oe_n),
        .FRAME_SELECT_LINE        (frame_n),
        .SHIFT_TIMING_INPUT       (shift),
        .SERIAL_INPUT_LINE        (ser),
        .DESC_BYTE                (desc),
        .DESC_VALID               (valid),
        .DESC_READY               (ready),
        .HID_STATE                (hid),
        .USB_NACK_ALL             (nack_all),
        .CMD_ERROR                (err)
    );

    dlis_rom_model #(.IMG_BYTES(DESC_BYTES)) i_dlis_rom_model (
        .clk       (clk),
        .scl       (scl_oe_n),
        .sda       (sda_w),
        .sda_low   (sda_low),
        .starts    (starts),
        .sent      (sent),
        .addr_ok   (addr_ok),
        .nack_last (nack_last),
        .stopped   (stopped)
    );

    always #4 clk = ~clk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (valid && ready) begin
            got_q.push_back(desc);
        end
        if (cycles == 90000) begin
            failures++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int k = 0; k < 8; k++) begin
            rev8[k] = v[7 - k];
        end
    endfunction

    // Shifts the top n bits of w, B15 first, then closes the frame
    task automatic send_word(input logic [15:0] w, input int n);
        frame_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int b = 15; b > 15 - n; b--) begin
            ser <= w[b];
            shift <= 1'b0;
            repeat (4) @(posedge clk);
            shift <= 1'b1;
            repeat (4) @(posedge clk);
        end
        shift <= 1'b0;
        repeat (4) @(posedge clk);
        frame_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask

    task automatic check_queue(input int n, input int base);
        check(got_q.size(), n);
        foreach (got_q[i]) begin
            check(got_q[i], {6'(i), 8'(base == 0 ? i_dlis_rom_model.img(i) : i ^ base), i >= 4 && i <= 51});
        end
        got_q.delete();
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        frame_n = 1'b1;
        shift = 1'b0;
        ser = 1'b0;
        ready = 1'b0;
        repeat (20) @(posedge clk);
        check({nack_all, sda_oe_n, scl_oe_n, valid, hid}, 12'he00);
        reset_n <= 1'b1;
        @(posedge scl_oe_n);
        t0 = $time;
        @(posedge scl_oe_n);
        check(32'($time - t0), 32'(4 * TB_QTR * 8));
        // Receiver stalls long enough for the buffer to refuse
        repeat (4000) @(posedge clk);
        ready <= 1'b1;
        while (sent != 56) @(posedge clk);
        check(nack_all, 1);
        while (!stopped) @(posedge clk);
        repeat (1000) @(posedge clk);
        check({nack_all, addr_ok, nack_last}, 3'b011);
        check_queue(57, 0);
        for (int i = 0; i < 8; i++) begin
            send_word({8'h00, rev8(8'h01 << i)}, 16);
            check(hid, 32'(8'h01 << i));
        end
        send_word({8'h00, rev8(8'h3c)}, 15);
        check(hid, 32'h80);
        send_word({8'h02, rev8(8'ha5)}, 16);
        check(hid, 32'ha5);
        // One word more than the image holds
        for (int i = 0; i < 58; i++) begin
            send_word({8'h08, rev8(8'(i ^ 8'h3c))}, 16);
        end
        check_queue(57, 8'h3c);
        check(err, 0);
        send_word({8'h0a, rev8(8'hff)}, 16);
        check({err, hid}, 9'h1a5);
        check(got_q.size() + starts, 1);
        summarize();
    end
endmodule // dlis_loader_tb_top
`default_nettype wire
